// >>> logic/mpio_pkg.sv
package mpio_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int unsigned REG_COUNT = 16;
  localparam int unsigned REG_IDX_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;

  // ****************************************
  // reset values and filter timing
  // ****************************************
  localparam logic [DATA_W-1:0] REG_RESET_VAL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET_VAL = 8'h00;
  localparam int unsigned RST_FILTER_STAGES = 2;

  // ****************************************
  // command kinds
  // ****************************************
  typedef enum logic [1:0] {
    MPIO_CMD_READ = 2'h0,
    MPIO_CMD_WRITE = 2'h1
  } mpio_kind_t;

  // io command from the core: register index, address source
  typedef struct packed {
    logic valid;
    mpio_kind_t kind;
    logic [REG_IDX_W-1:0] data_reg;
    logic addr_indirect;
    logic [REG_IDX_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_const;
  } mpio_cmd_t;

  // one-hot sequencer states
  typedef enum logic [2:0] {
    MPIO_IDLE = 3'b001,
    MPIO_CYC1 = 3'b010,
    MPIO_CYC2 = 3'b100
  } mpio_state_t;

endpackage : mpio_pkg

// >>> logic/mpio_port_io.sv
`timescale 1ns/100ps
`default_nettype none

module mpio_port_io
  import mpio_pkg::*;
(
  // clock and reset
  input wire logic MCLK_IN,
  input wire logic ARST_N_IN,
  input wire logic USER_RST_IN,
  // io command from the core
  input wire mpio_cmd_t CMD_IN,
  output logic CMD_READY_OUT,
  output logic CMD_DONE_OUT,
  // flags kept across port instructions
  input wire logic ZERO_IN,
  input wire logic CARRY_IN,
  input wire logic FLAG_LOAD_IN,
  output logic ZERO_OUT,
  output logic CARRY_OUT,
  // register file access for the core
  input wire logic RF_WE_IN,
  input wire logic [REG_IDX_W-1:0] RF_WIDX_IN,
  input wire logic [DATA_W-1:0] RF_WDATA_IN,
  input wire logic [REG_IDX_W-1:0] RF_RIDX_IN,
  output logic [DATA_W-1:0] RF_RDATA_OUT,
  // port bus toward user logic
  output logic [ADDR_W-1:0] IO_PORT_ADDRESS_OUT,
  input wire logic [DATA_W-1:0] RD_DATA_IN,
  output logic [DATA_W-1:0] WR_DATA_OUT,
  output logic RD_STROBE_OUT,
  output logic WR_STROBE_OUT,
  // conditioned reset
  output logic INT_RST_OUT
);

  // ****************************************
  // reset conditioning
  // ****************************************
  logic usr_rst_s1_q;
  logic usr_rst_s2_q;
  logic [RST_FILTER_STAGES-1:0] rst_filt_q;
  logic int_rst;

  // user reset synchronised; first stage feeds only the second
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      usr_rst_s1_q <= 1'b1;
      usr_rst_s2_q <= 1'b1;
    end else begin
      usr_rst_s1_q <= USER_RST_IN;
      usr_rst_s2_q <= usr_rst_s1_q;
    end
  end

  // filter shifts zeros in; held set after power-up even with input tied low
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rst_filt_q <= '1;
    end else if (usr_rst_s2_q) begin
      rst_filt_q <= '1;
    end else begin
      rst_filt_q <= {rst_filt_q[RST_FILTER_STAGES-2:0], 1'b0};
    end
  end

  assign int_rst = rst_filt_q[RST_FILTER_STAGES-1];
  assign INT_RST_OUT = int_rst;

  // ****************************************
  // register file
  // ****************************************
  logic [DATA_W-1:0] regs_q [REG_COUNT];
  logic [DATA_W-1:0] regs_d [REG_COUNT];

  function automatic logic [DATA_W-1:0] rf_read(input logic [REG_IDX_W-1:0] idx,
                                                input logic [DATA_W-1:0] r [REG_COUNT]);
    rf_read = r[idx];
  endfunction : rf_read

  // ****************************************
  // port sequencer
  // ****************************************
  mpio_state_t state_q;
  mpio_state_t state_d;
  mpio_kind_t kind_q;
  logic [REG_IDX_W-1:0] dst_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] wdata_d;
  logic zero_q;
  logic carry_q;
  logic take_cmd;
  logic in_cyc2;
  logic rd_cap;

  assign take_cmd = CMD_IN.valid && (state_q == MPIO_IDLE) && !int_rst;
  assign in_cyc2 = (state_q == MPIO_CYC2);
  assign rd_cap = in_cyc2 && (kind_q == MPIO_CMD_READ);
  assign CMD_READY_OUT = (state_q == MPIO_IDLE) && !int_rst;
  assign CMD_DONE_OUT = in_cyc2;

  // address from constant or indirect register
  assign addr_d = CMD_IN.addr_indirect ? rf_read(CMD_IN.addr_reg, regs_q)
                                       : CMD_IN.addr_const;
  // write data from named source register
  assign wdata_d = rf_read(CMD_IN.data_reg, regs_q);

  // next-state: two cycles per port operation
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      MPIO_IDLE: begin
        if (take_cmd) begin
          state_d = MPIO_CYC1;
        end
      end
      MPIO_CYC1: begin
        state_d = MPIO_CYC2;
      end
      MPIO_CYC2: begin
        state_d = MPIO_IDLE;
      end
      default: begin
        state_d = MPIO_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state_q <= MPIO_IDLE;
    end else if (int_rst) begin
      state_q <= MPIO_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // latch address, kind and data only when a command is taken
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      kind_q <= MPIO_CMD_READ;
      dst_q <= '0;
      addr_q <= ADDR_RESET_VAL;
      wdata_q <= REG_RESET_VAL;
    end else if (take_cmd) begin
      kind_q <= CMD_IN.kind;
      dst_q <= CMD_IN.data_reg;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
    end
  end

  assign IO_PORT_ADDRESS_OUT = addr_q;
  assign WR_DATA_OUT = wdata_q;
  // strobes are combinational so they meet single-cycle timing from state
  assign WR_STROBE_OUT = in_cyc2 && (kind_q == MPIO_CMD_WRITE);
  assign RD_STROBE_OUT = rd_cap;

  // register writes: read capture wins over a core write in the same cycle
  always_comb begin
    for (int i = 0; i < REG_COUNT; i++) begin
      regs_d[i] = regs_q[i];
    end
    if (RF_WE_IN) begin
      regs_d[RF_WIDX_IN] = RF_WDATA_IN;
    end
    if (rd_cap) begin
      regs_d[dst_q] = RD_DATA_IN;
    end
  end

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= REG_RESET_VAL;
      end
    end else begin
      regs_q <= regs_d;
    end
  end

  assign RF_RDATA_OUT = rf_read(RF_RIDX_IN, regs_q);

  // flags: port operations never load them
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      zero_q <= 1'b0;
      carry_q <= 1'b0;
    end else if (int_rst) begin
      zero_q <= 1'b0;
      carry_q <= 1'b0;
    end else if (FLAG_LOAD_IN && (state_q == MPIO_IDLE)) begin
      zero_q <= ZERO_IN;
      carry_q <= CARRY_IN;
    end
  end

  assign ZERO_OUT = zero_q;
  assign CARRY_OUT = carry_q;

  // ****************************************
  // checks
  // ****************************************
  chk_addr_stable: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    (state_q == MPIO_CYC1) |=> $stable(IO_PORT_ADDRESS_OUT))
    else $error("port address changed during operation");

  chk_wr_second: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    WR_STROBE_OUT |-> $past(state_q == MPIO_CYC1) && (kind_q == MPIO_CMD_WRITE))
    else $error("write strobe outside second cycle");

  chk_rd_capture: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    RD_STROBE_OUT |=> (regs_q[$past(dst_q)] == $past(RD_DATA_IN)))
    else $error("read byte not captured");

  chk_strobe_pulse: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    (RD_STROBE_OUT || WR_STROBE_OUT) |=> !(RD_STROBE_OUT || WR_STROBE_OUT))
    else $error("strobe longer than one cycle");

  chk_strobe_excl: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    !(RD_STROBE_OUT && WR_STROBE_OUT))
    else $error("both strobes high");

  // a user reset in mid-operation legally cuts the strobe, so it disables the check
  chk_wdata_hold: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN || int_rst)
    (take_cmd && CMD_IN.kind == MPIO_CMD_WRITE) |=> ##1
      (WR_STROBE_OUT && WR_DATA_OUT == $past(wdata_d, 2)))
    else $error("write data not source value at strobe");

  chk_addr_source: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    take_cmd |=> (IO_PORT_ADDRESS_OUT == $past(addr_d)) ##1
      (IO_PORT_ADDRESS_OUT == $past(addr_d, 2)))
    else $error("port address not from its source");

  // internal reset clears the flags on purpose, even in mid-operation
  chk_flags_kept: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN || int_rst)
    (state_q != MPIO_IDLE) |=> $stable(ZERO_OUT) && $stable(CARRY_OUT))
    else $error("flags changed by port operation");

  chk_reset_hold: assert property (@(posedge MCLK_IN) disable iff (!ARST_N_IN)
    usr_rst_s2_q |=> INT_RST_OUT [*2])
    else $error("internal reset released too early");

endmodule : mpio_port_io

`default_nettype wire

// >>> verif/mpio_user_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// user port logic beside the core
// ****************************************
module mpio_user_model
  import mpio_pkg::*;
(
  // clock
  input wire logic MCLK_IN,
  // port bus from the core
  input wire logic [ADDR_W-1:0] ADDR_IN,
  input wire logic RD_STROBE_IN,
  input wire logic WR_STROBE_IN,
  input wire logic [DATA_W-1:0] WR_DATA_IN,
  // read data and observed results
  output logic [DATA_W-1:0] RD_DATA_OUT,
  output logic [DATA_W-1:0] CAP_DATA_OUT,
  output logic [ADDR_W-1:0] CAP_ADDR_OUT,
  output logic [7:0] RD_COUNT_OUT
);
  // decoded byte only in the strobe cycle, inverted otherwise so a late sample shows
  assign RD_DATA_OUT = RD_STROBE_IN ? (ADDR_IN ^ 8'h5a) : ~(ADDR_IN ^ 8'h5a);
  initial begin
    CAP_DATA_OUT = 8'h00;
    CAP_ADDR_OUT = 8'h00;
    RD_COUNT_OUT = 8'h00;
  end
  // capture gated by the write strobe, read strobe counts bytes taken
  always @(posedge MCLK_IN) begin
    if (WR_STROBE_IN) begin
      CAP_DATA_OUT <= WR_DATA_IN;
      CAP_ADDR_OUT <= ADDR_IN;
    end
    if (RD_STROBE_IN) RD_COUNT_OUT <= RD_COUNT_OUT + 8'h01;
  end
endmodule : mpio_user_model
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import mpio_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic clk = 1'b0, rst_n = 1'b0, urst = 1'b0, zi = 1'b0, ci = 1'b0, fl = 1'b0, rfwe = 1'b0;
  logic [3:0] rfwi = 4'h0, rfri = 4'h0;
  logic [7:0] rfwd = 8'h00, rfrd, addr, rdd, wrd, cap_d, cap_a, rd_cnt;
  logic ready, done, zo, co, rds, wrs, irst;
  mpio_cmd_t cmd = '0;
  int err_total = 0, check_count = 0;
  always #25 clk = ~clk;
  mpio_port_io DUT (.MCLK_IN(clk), .ARST_N_IN(rst_n), .USER_RST_IN(urst), .CMD_IN(cmd),
    .CMD_READY_OUT(ready), .CMD_DONE_OUT(done), .ZERO_IN(zi), .CARRY_IN(ci),
    .FLAG_LOAD_IN(fl), .ZERO_OUT(zo), .CARRY_OUT(co), .RF_WE_IN(rfwe), .RF_WIDX_IN(rfwi),
    .RF_WDATA_IN(rfwd), .RF_RIDX_IN(rfri), .RF_RDATA_OUT(rfrd), .IO_PORT_ADDRESS_OUT(addr),
    .RD_DATA_IN(rdd), .WR_DATA_OUT(wrd), .RD_STROBE_OUT(rds), .WR_STROBE_OUT(wrs),
    .INT_RST_OUT(irst));
  mpio_user_model PEER (.MCLK_IN(clk), .ADDR_IN(addr), .RD_STROBE_IN(rds), .WR_STROBE_IN(wrs),
    .WR_DATA_IN(wrd), .RD_DATA_OUT(rdd), .CAP_DATA_OUT(cap_d), .CAP_ADDR_OUT(cap_a),
    .RD_COUNT_OUT(rd_cnt));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // bounded wait on a design flag, sampled mid-cycle
  task automatic wait_for(input string nm, input logic lvl, ref logic sig);
    int n;
    for (n = 0; n < 20 && sig !== lvl; n++) @(negedge clk);
    if (sig !== lvl) begin
      chk(nm, {7'h0, lvl}, {7'h0, sig});
      report_and_stop();
    end
  endtask : wait_for
  task automatic rf_wr(input logic [3:0] i, input logic [7:0] v);
    @(posedge clk);
    rfwe <= 1'b1; rfwi <= i; rfwd <= v;
    @(posedge clk);
    rfwe <= 1'b0;
  endtask : rf_wr
  task automatic rf_chk(input logic [3:0] i, input logic [7:0] v);
    @(posedge clk);
    rfri <= i;
    @(negedge clk);
    chk("reg", v, rfrd);
  endtask : rf_chk
  // one port command, walked cycle by cycle
  task automatic issue(input mpio_kind_t k, input logic [3:0] d, input logic ind,
      input logic [3:0] ar, input logic [7:0] ac, input logic [7:0] ea, input logic [7:0] ed);
    logic wr;
    wr = (k == MPIO_CMD_WRITE);
    wait_for("ready", 1'b1, ready);
    @(posedge clk);
    cmd <= '{valid: 1'b1, kind: k, data_reg: d, addr_indirect: ind, addr_reg: ar, addr_const: ac};
    @(posedge clk);
    cmd.valid <= 1'b0;
    @(negedge clk);
    chk("addr c1", ea, addr);
    chk("strobes c1", 8'h00, {6'h0, rds, wrs});
    if (wr) chk("wdata c1", ed, wrd);
    @(negedge clk);
    chk("addr c2", ea, addr);
    chk("strobes c2", {6'h0, ~wr, wr}, {6'h0, rds, wrs});
    chk("done c2", 8'h01, {7'h0, done});
    if (wr) chk("wdata c2", ed, wrd);
    @(negedge clk);
    chk("strobes c3", 8'h00, {6'h0, rds, wrs});
  endtask : issue
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_power_up();
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("irst held", 8'h01, {7'h0, irst});
    wait_for("irst release", 1'b0, irst);
    rf_chk(4'h5, REG_RESET_VAL);
  endtask : t_power_up
  task automatic t_writes();
    rf_wr(4'h3, 8'ha7);
    rf_wr(4'hf, 8'h00);
    rf_wr(4'h0, 8'h3c);
    issue(MPIO_CMD_WRITE, 4'h3, 1'b0, 4'h0, 8'hff, 8'hff, 8'ha7);
    chk("cap data", 8'ha7, cap_d);
    chk("cap addr", 8'hff, cap_a);
    issue(MPIO_CMD_WRITE, 4'h0, 1'b1, 4'hf, 8'h99, 8'h00, 8'h3c);
    chk("cap data ind", 8'h3c, cap_d);
  endtask : t_writes
  task automatic t_reads();
    logic [7:0] a;
    for (int i = 0; i < 16; i++) begin
      a = {i[3:0], ~i[3:0]};
      issue(MPIO_CMD_READ, i[3:0], 1'b0, 4'h0, a, a, 8'h00);
      rf_chk(i[3:0], a ^ 8'h5a);
    end
    chk("read count", 8'h10, rd_cnt);
    rf_wr(4'ha, 8'h81);
    issue(MPIO_CMD_READ, 4'he, 1'b1, 4'ha, 8'h00, 8'h81, 8'h00);
    rf_chk(4'he, 8'h81 ^ 8'h5a);
  endtask : t_reads
  task automatic t_flags();
    @(posedge clk);
    zi <= 1'b1; ci <= 1'b0; fl <= 1'b1;
    @(posedge clk);
    fl <= 1'b0; zi <= 1'b0; ci <= 1'b1;
    // reg 3 was last filled by the read loop from port 3c
    issue(MPIO_CMD_WRITE, 4'h3, 1'b0, 4'h0, 8'h12, 8'h12, 8'h3c ^ 8'h5a);
    issue(MPIO_CMD_READ, 4'h2, 1'b0, 4'h0, 8'h34, 8'h34, 8'h00);
    chk("flags", 8'h02, {6'h0, zo, co});
  endtask : t_flags
  task automatic t_user_reset();
    @(posedge clk);
    urst <= 1'b1;
    wait_for("user irst", 1'b1, irst);
    chk("ready in reset", 8'h00, {7'h0, ready});
    @(posedge clk);
    urst <= 1'b0;
    wait_for("user release", 1'b0, irst);
    // user reset leaves the register file alone, so reg 3 keeps its read byte
    issue(MPIO_CMD_WRITE, 4'h3, 1'b0, 4'h0, 8'h01, 8'h01, 8'h3c ^ 8'h5a);
  endtask : t_user_reset
  initial begin
    t_power_up();
    t_writes();
    t_reads();
    t_flags();
    t_user_reset();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
